//--- pkg/tsi_regs.svh
/*
 * Named offsets, field values and timing counts for the two-wire
 * temperature sensor target and its host. Definitions only; included by
 * every design file that needs a number.
 */
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH

`define TSI_CLK_NS 50
`define TSI_SPIKE_NS 50
`define TSI_SPIKE_CYC ((`TSI_SPIKE_NS + `TSI_CLK_NS - 1) / `TSI_CLK_NS)
`define TSI_SCL_PERIOD_NS 2500
`define TSI_QUARTER_NS (`TSI_SCL_PERIOD_NS / 4)
`define TSI_QUARTER_CYC ((`TSI_QUARTER_NS + `TSI_CLK_NS - 1) / `TSI_CLK_NS)

`define TSI_BASE_ADDR 7'h48
`define TSI_BASE_HI2 2'h2
`define TSI_BASE_HI5 5'h12
`define TSI_PTR_RESET 8'h00
`define TSI_PTR_TEMP 4'h0
`define TSI_TEMP_RESET 16'h0000
`define TSI_UNMAPPED_WORD 16'h0000
`define TSI_BITS_PER_BYTE 4'h8

`define TSI_PIN_LOW 2'h0
`define TSI_PIN_HIGH 2'h1
`define TSI_PIN_SDA 2'h2
`define TSI_PIN_SCL 2'h3

`define TSI_H_TARGET 4'h0
`define TSI_H_POINTER 4'h1
`define TSI_H_CTRL 4'h2
`define TSI_H_STATUS 4'h3
`define TSI_H_DATA 4'h4
`define TSI_H_CTRL_WPTR 0
`define TSI_H_CTRL_RDW 1
`define TSI_H_ST_BUSY 0
`define TSI_H_ST_NACK 1

`endif

//--- pkg/tsi_pkg.sv
/*
 * Types shared by the two-wire sensor target and its host.
 * Assumes tsi_regs.svh for all numeric values.
 */
package tsi_pkg;
	// nine target states need four bits
	typedef enum logic [3:0] {
		TSI_T_IDLE,
		TSI_T_ADDR,
		TSI_T_AACK,
		TSI_T_RX,
		TSI_T_RACK,
		TSI_T_TX,
		TSI_T_TACK,
		TSI_T_TNEXT,
		TSI_T_IGNORE
	} tsi_tstate_t;

	typedef enum logic [1:0] {
		TSI_H_IDLE,
		TSI_H_START,
		TSI_H_BIT,
		TSI_H_STOP
	} tsi_hstate_t;
endpackage

//--- pkg/tsi_if.sv
/*
 * Two-wire bus between host and target: open-drain wires resolved here
 * with a pull-up. Assumes enables are active low (low = driving).
 */
`timescale 1ns/1ps
interface tsi_if;
	logic scl_o;
	logic scl_oe_b;
	logic hsda_o;
	logic hsda_oe_b;
	logic tsda_o;
	logic tsda_oe_b;
	logic scl;
	logic sda;

	// pull-up wins whenever nobody drives low
	assign scl = scl_oe_b | scl_o;
	assign sda = (hsda_oe_b | hsda_o) & (tsda_oe_b | tsda_o);

	modport host (
		output scl_o,
		output scl_oe_b,
		output hsda_o,
		output hsda_oe_b,
		input scl,
		input sda
	);
	modport target (
		output tsda_o,
		output tsda_oe_b,
		input scl,
		input sda
	);
endinterface

//--- design/tsi_filt.sv
/*
 * Three-stage synchroniser with spike filter for one pin.
 * Assumes the pin is asynchronous to mclk_i.
 */
`timescale 1ns/1ps
`include "tsi_regs.svh"
module tsi_filt #(
	parameter bit RST_VAL = 1'b1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// pin and filtered level
	input wire logic pin_i,
	output logic level_o
);
	logic s1;
	logic s2;
	logic s3;
	logic [2:0] stable;
	wire agree = (s2 == s3) && (s3 != level_o);
	// a change only counts once stage two and three agree long enough
	wire settled = agree && (stable >= 3'(`TSI_SPIKE_CYC - 1));

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			stable <= 3'h0;
			level_o <= RST_VAL;
		end
		else
		begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			stable <= agree ? stable + 3'h1 : 3'h0;
			if (settled)
				level_o <= s3;
		end
	end
endmodule // tsi_filt

//--- design/tsi_target.sv
/*
 * Target end of the two-wire temperature sensor: bus framing, strapped
 * address, pointer and 16-bit temperature register holding a 12-bit result.
 * Assumes the host makes the clock and keeps the bus protocol; the
 * converter delivers results as a one-cycle valid with data.
 */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tsi_regs.svh"
module tsi_target #(
	parameter bit FULL_PINS = 1'b0
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// two-wire bus
	tsi_if.target bus,
	// address straps
	input wire logic addr_select_pin_0_i,
	input wire logic addr_select_pin_1_i,
	input wire logic addr_select_pin_2_i,
	// converter result
	input wire logic [11:0] conv_result_i,
	input wire logic conv_valid_i,
	// status
	output logic [7:0] reg_select_pointer_o,
	output logic [15:0] temperature_result_o,
	output logic busy_o
);
	// classify one strap from its level at idle, at start, at first clock low
	function automatic logic [1:0] pin_code(input logic idle, input logic st, input logic lo);
		if (!idle)
			pin_code = `TSI_PIN_LOW;
		else if (!st)
			pin_code = `TSI_PIN_SDA;
		else if (!lo)
			pin_code = `TSI_PIN_SCL;
		else
			pin_code = `TSI_PIN_HIGH;
	endfunction

	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;
	logic [2:0] pin_raw;
	logic [2:0] pin_f;

	assign pin_raw = {addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i};

	tsi_filt #(.RST_VAL(1'b1)) u_scl (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(bus.scl),
		.level_o(scl_f));
	tsi_filt #(.RST_VAL(1'b1)) u_sda (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(bus.sda),
		.level_o(sda_f));

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pin
			tsi_filt #(.RST_VAL(1'b0)) u_pin (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
				.pin_i(pin_raw[gi]), .level_o(pin_f[gi]));
		end
	endgenerate

	tsi_pkg::tsi_tstate_t state;
	tsi_pkg::tsi_tstate_t next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic rw;
	logic next_rw;
	logic bidx;
	logic next_bidx;
	logic [15:0] snap;
	logic [15:0] next_snap;
	logic oe_b;
	logic next_oe_b;
	logic [2:0] pin_idle;
	logic [2:0] next_pin_idle;
	logic [2:0] pin_st;
	logic [2:0] next_pin_st;
	logic [2:0] pin_lo;
	logic [2:0] next_pin_lo;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [15:0] temp;
	logic drive_lvl;

	// edges and bus conditions on the filtered lines
	// filter latency of a few cycles bounds the usable bus clock rate
	wire scl_rise = scl_f & ~scl_q;
	wire scl_fall = ~scl_f & scl_q;
	wire start_c = sda_q & ~sda_f & scl_f & scl_q;
	wire stop_c = ~sda_q & sda_f & scl_f & scl_q;
	wire byte_done = (cnt == `TSI_BITS_PER_BYTE);

	wire [1:0] code0 = pin_code(pin_idle[0], pin_st[0], pin_lo[0]);
	wire [1:0] code1 = pin_code(pin_idle[1], pin_st[1], pin_lo[1]);
	wire [1:0] code2 = pin_code(pin_idle[2], pin_st[2], pin_lo[2]);
	// reduced variant uses only the first strap
	wire [6:0] addr_small = {`TSI_BASE_HI5, code0};
	wire [6:0] addr_full = {`TSI_BASE_HI2, code2[0], code1, code0};
	wire [6:0] own_addr = FULL_PINS ? addr_full : addr_small;
	wire addr_hit = (sh[7:1] == own_addr);
	// only the temperature register lives here; other pointers read zero
	wire [15:0] sel_word = (ptr[3:0] == `TSI_PTR_TEMP) ? temp : `TSI_UNMAPPED_WORD;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_sh = sh;
		next_rw = rw;
		next_bidx = bidx;
		next_snap = snap;
		next_oe_b = oe_b;
		next_pin_idle = pin_idle;
		next_pin_st = pin_st;
		next_pin_lo = pin_lo;
		next_ptr = ptr;
		if (stop_c)
		begin
			next_state = tsi_pkg::TSI_T_IDLE;
			next_oe_b = 1'b1;
		end
		else if (start_c)
		begin
			next_state = tsi_pkg::TSI_T_ADDR;
			next_cnt = 4'h0;
			next_oe_b = 1'b1;
			next_pin_st = pin_f;
		end
		else
		begin
			case (state)
				tsi_pkg::TSI_T_IDLE:
				begin
					if (scl_f && sda_f)
						next_pin_idle = pin_f;
				end
				tsi_pkg::TSI_T_ADDR:
				begin
					if (scl_rise)
					begin
						next_sh = {sh[6:0], sda_f};
						next_cnt = cnt + 4'h1;
					end
					if (scl_fall && cnt == 4'h0)
						next_pin_lo = pin_f;
					if (scl_fall && byte_done)
					begin
						if (addr_hit)
						begin
							next_oe_b = 1'b0;
							next_rw = sh[0];
							next_snap = sel_word;
							next_state = tsi_pkg::TSI_T_AACK;
						end
						else
							next_state = tsi_pkg::TSI_T_IGNORE;
					end
				end
				tsi_pkg::TSI_T_AACK:
				begin
					if (scl_fall)
					begin
						next_cnt = 4'h0;
						next_bidx = 1'b0;
						if (rw)
						begin
							next_sh = snap[15:8];
							next_oe_b = snap[15];
							next_state = tsi_pkg::TSI_T_TX;
						end
						else
						begin
							next_oe_b = 1'b1;
							next_state = tsi_pkg::TSI_T_RX;
						end
					end
				end
				tsi_pkg::TSI_T_RX:
				begin
					if (scl_rise)
					begin
						next_sh = {sh[6:0], sda_f};
						next_cnt = cnt + 4'h1;
					end
					if (scl_fall && byte_done)
					begin
						next_oe_b = 1'b0;
						next_state = tsi_pkg::TSI_T_RACK;
						next_bidx = 1'b1;
						if (!bidx)
							next_ptr = {4'h0, sh[3:0]};
						// later bytes would target read-only storage: dropped
					end
				end
				tsi_pkg::TSI_T_RACK:
				begin
					if (scl_fall)
					begin
						next_oe_b = 1'b1;
						next_cnt = 4'h0;
						next_state = tsi_pkg::TSI_T_RX;
					end
				end
				tsi_pkg::TSI_T_TX:
				begin
					if (scl_rise)
						next_cnt = cnt + 4'h1;
					if (scl_fall)
					begin
						if (byte_done)
						begin
							next_oe_b = 1'b1;
							next_state = tsi_pkg::TSI_T_TACK;
						end
						else
						begin
							next_sh = {sh[6:0], 1'b0};
							next_oe_b = sh[6];
						end
					end
				end
				tsi_pkg::TSI_T_TACK:
				begin
					if (scl_rise)
					begin
						if (sda_f)
							next_state = tsi_pkg::TSI_T_IGNORE;
						else
						begin
							next_bidx = ~bidx;
							next_state = tsi_pkg::TSI_T_TNEXT;
						end
					end
				end
				tsi_pkg::TSI_T_TNEXT:
				begin
					if (scl_fall)
					begin
						next_sh = bidx ? snap[7:0] : snap[15:8];
						next_oe_b = bidx ? snap[7] : snap[15];
						next_cnt = 4'h0;
						next_state = tsi_pkg::TSI_T_TX;
					end
				end
				tsi_pkg::TSI_T_IGNORE:
				begin
					next_oe_b = 1'b1;
				end
				default:
				begin
					next_state = tsi_pkg::TSI_T_IDLE;
					next_oe_b = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= tsi_pkg::TSI_T_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			rw <= 1'b0;
			bidx <= 1'b0;
			snap <= `TSI_TEMP_RESET;
			oe_b <= 1'b1;
			pin_idle <= 3'h0;
			pin_st <= 3'h0;
			pin_lo <= 3'h0;
			ptr <= `TSI_PTR_RESET;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			sh <= next_sh;
			rw <= next_rw;
			bidx <= next_bidx;
			snap <= next_snap;
			oe_b <= next_oe_b;
			pin_idle <= next_pin_idle;
			pin_st <= next_pin_st;
			pin_lo <= next_pin_lo;
			ptr <= next_ptr;
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	// one load per valid keeps a read snapshot whole
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			temp <= `TSI_TEMP_RESET;
		else if (conv_valid_i)
			temp <= {conv_result_i, 4'h0};
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			drive_lvl <= 1'b0;
			busy_o <= 1'b0;
			reg_select_pointer_o <= `TSI_PTR_RESET;
			temperature_result_o <= `TSI_TEMP_RESET;
		end
		else
		begin
			drive_lvl <= 1'b0;
			busy_o <= (next_state != tsi_pkg::TSI_T_IDLE);
			reg_select_pointer_o <= next_ptr;
			temperature_result_o <= conv_valid_i ? {conv_result_i, 4'h0} : temp;
		end
	end

	assign bus.tsda_o = drive_lvl;
	assign bus.tsda_oe_b = oe_b;
endmodule // tsi_target

//--- design/tsi_host.sv
/*
 * Host end of the two-wire bus: makes the clock by a divider and runs
 * pointer-write and word-read transactions ordered through registers.
 * Assumes a software port with reads answered one cycle later.
 */
`timescale 1ns/1ps
`include "tsi_regs.svh"
module tsi_host (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// two-wire bus
	tsi_if.host bus,
	// software port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o
);
	logic sda_f;
	tsi_filt #(.RST_VAL(1'b1)) u_sda (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(bus.sda),
		.level_o(sda_f));

	tsi_pkg::tsi_hstate_t state;
	logic [6:0] target;
	logic [7:0] ptr;
	logic [15:0] data;
	logic nack;
	logic rdop;
	logic [1:0] step;
	logic [1:0] ph;
	logic [3:0] bitn;
	logic [7:0] sh;
	logic [4:0] qcnt;
	logic scl_oe_b;
	logic sda_oe_b;

	wire busy = (state != tsi_pkg::TSI_H_IDLE);
	wire tick = (qcnt == 5'(`TSI_QUARTER_CYC - 1));
	wire go = wr_i && (addr_i == `TSI_H_CTRL) && !busy;
	// step 0 is the address byte; read steps 1 and 2 receive
	wire rx_step = rdop && (step != 2'h0);
	wire [1:0] last_step = rdop ? 2'h2 : 2'h1;
	wire [7:0] next_byte = rdop ? 8'h00 : ptr;
	wire ack_out = !(rdop && step == 2'h2);
	wire [15:0] st_word = {14'h0, nack, busy};
	wire [15:0] rd_word =
		(addr_i == `TSI_H_TARGET) ? {9'h0, target} :
		(addr_i == `TSI_H_POINTER) ? {8'h0, ptr} :
		(addr_i == `TSI_H_STATUS) ? st_word :
		(addr_i == `TSI_H_DATA) ? data : 16'h0000;

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			target <= `TSI_BASE_ADDR;
			ptr <= `TSI_PTR_RESET;
			rdata_o <= 16'h0000;
		end
		else
		begin
			if (wr_i && addr_i == `TSI_H_TARGET)
				target <= wdata_i[6:0];
			if (wr_i && addr_i == `TSI_H_POINTER)
				ptr <= wdata_i[7:0];
			rdata_o <= rd_i ? rd_word : 16'h0000;
		end
	end

	// quarter-period divider; the bus clock only exists during a transaction
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			qcnt <= 5'h00;
		else if (!busy || tick)
			qcnt <= 5'h00;
		else
			qcnt <= qcnt + 5'h01;
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= tsi_pkg::TSI_H_IDLE;
			scl_oe_b <= 1'b1;
			sda_oe_b <= 1'b1;
			data <= 16'h0000;
			nack <= 1'b0;
			rdop <= 1'b0;
			step <= 2'h0;
			ph <= 2'h0;
			bitn <= 4'h0;
			sh <= 8'h00;
		end
		else if (go && (wdata_i[`TSI_H_CTRL_WPTR] || wdata_i[`TSI_H_CTRL_RDW]))
		begin
			state <= tsi_pkg::TSI_H_START;
			rdop <= wdata_i[`TSI_H_CTRL_RDW];
			nack <= 1'b0;
			step <= 2'h0;
			ph <= 2'h0;
		end
		else if (busy && tick)
		begin
			ph <= ph + 2'h1;
			case (state)
				tsi_pkg::TSI_H_START:
				begin
					if (ph == 2'h1)
						sda_oe_b <= 1'b0;
					if (ph == 2'h3)
					begin
						scl_oe_b <= 1'b0;
						sh <= {target, rdop};
						bitn <= 4'h0;
						state <= tsi_pkg::TSI_H_BIT;
					end
				end
				tsi_pkg::TSI_H_BIT:
				begin
					// data moves two quarters after the clock falls, never beside it
					if (ph == 2'h1)
					begin
						if (bitn != `TSI_BITS_PER_BYTE)
							sda_oe_b <= rx_step ? 1'b1 : sh[7];
						else
							sda_oe_b <= rx_step ? !ack_out : 1'b1;
					end
					if (ph == 2'h2)
						scl_oe_b <= 1'b1;
					if (ph == 2'h3)
					begin
						scl_oe_b <= 1'b0;
						bitn <= bitn + 4'h1;
						sh <= {sh[6:0], sda_f};
						if (bitn == 4'h7 && rx_step)
							data <= (step == 2'h1) ? {sh[6:0], sda_f, data[7:0]} :
								{data[15:8], sh[6:0], sda_f};
						if (bitn == `TSI_BITS_PER_BYTE)
						begin
							bitn <= 4'h0;
							sh <= next_byte;
							step <= step + 2'h1;
							if ((!rx_step && sda_f) || step == last_step)
							begin
								nack <= !rx_step && sda_f;
								state <= tsi_pkg::TSI_H_STOP;
							end
						end
					end
				end
				tsi_pkg::TSI_H_STOP:
				begin
					if (ph == 2'h1)
						sda_oe_b <= 1'b0;
					if (ph == 2'h2)
						scl_oe_b <= 1'b1;
					if (ph == 2'h3)
					begin
						sda_oe_b <= 1'b1;
						state <= tsi_pkg::TSI_H_IDLE;
					end
				end
				default:
				begin
					state <= tsi_pkg::TSI_H_IDLE;
					scl_oe_b <= 1'b1;
					sda_oe_b <= 1'b1;
				end
			endcase
		end
	end

	assign bus.scl_o = 1'b0;
	assign bus.hsda_o = 1'b0;
	assign bus.scl_oe_b = scl_oe_b;
	assign bus.hsda_oe_b = sda_oe_b;
endmodule // tsi_host

//--- tb/tsi_asserts.sv
/*
 * Concurrent checks on the two-wire bus between host and target.
 * Assumes the plain interface signals and the 20 MHz system clock.
 */
`timescale 1ns/1ps
module tsi_asserts (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// bus wires
	input wire logic scl_o,
	input wire logic scl_oe_b,
	input wire logic hsda_o,
	input wire logic hsda_oe_b,
	input wire logic tsda_o,
	input wire logic tsda_oe_b,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic idle;
	logic [3:0] nbit;
	logic [7:0] since_rise;
	wire scl_up = scl & ~scl_q;
	wire start_seen = scl & scl_q & sda_q & ~sda;
	wire stop_seen = scl & scl_q & ~sda_q & sda;

	// edge history of the resolved wires
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			idle <= 1'b1;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			idle <= stop_seen | (idle & ~start_seen);
		end

	// saturating counts, so a long idle never wraps into a false short period
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			nbit <= 4'h0;
			since_rise <= 8'hFF;
		end
		else
		begin
			if (start_seen)
				nbit <= 4'h0;
			else if (scl_up && nbit != 4'hF)
				nbit <= nbit + 4'h1;
			if (scl_up)
				since_rise <= 8'h00;
			else if (since_rise != 8'hFF)
				since_rise <= since_rise + 8'h01;
		end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_drive_level_low: assert property (!scl_o && !hsda_o && !tsda_o)
		else $error("open-drain level not low");
	a_reset_bus_free: assert property ($rose(rst_b_i) |-> scl_oe_b && hsda_oe_b && tsda_oe_b)
		else $error("bus not released after reset");
	a_sda_change_low: assert property ($changed(tsda_oe_b) |-> !scl)
		else $error("target data moved while clock high");
	a_start_by_host: assert property (start_seen |-> !hsda_oe_b)
		else $error("start not made by host");
	a_addr_no_drive: assert property (scl_up && nbit < 4'h8 |-> tsda_oe_b)
		else $error("target drove data during address");
	a_ack_ninth_held: assert property (scl_up && nbit == 4'h8 && !tsda_oe_b |-> (!tsda_oe_b)[*8])
		else $error("acknowledge dropped in clock high");
	a_idle_released: assert property (idle |-> tsda_oe_b)
		else $error("target drives data after stop");
	a_clock_rate_fast: assert property (scl_up |-> since_rise >= 8'h31)
		else $error("clock period below fast-mode limit");
endmodule // tsi_asserts

//--- tb/tb.sv
/*
 * Self-checking bench: host and target joined by the bus interface.
 * Assumes a 20 MHz clock and no other party on the bus.
 */
`timescale 1ns/1ps
module tb;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] rdata_o;
	logic [11:0] conv_result_i = 12'h000;
	logic conv_valid_i = 1'b0;
	logic [1:0] strap = 2'h0;
	logic strap_hi = 1'b0;
	logic [7:0] reg_select_pointer_o;
	logic [15:0] temperature_result_o;
	logic busy_o;
	logic [15:0] v;
	logic [13:0] rows [6] = '{14'h07FF, 14'h1FFF, 14'h2640, 14'h3FFC, 14'h0800, 14'h1001};
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;

	tsi_if bus_if ();
	wire pin0 = strap[1] ? (strap[0] ? bus_if.scl : bus_if.sda) : strap[0];
	tsi_host i_tsi_host (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus(bus_if.host),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	tsi_target #(.FULL_PINS(1'b0)) i_tsi_target (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.bus(bus_if.target), .addr_select_pin_0_i(pin0), .addr_select_pin_1_i(strap_hi),
		.addr_select_pin_2_i(strap_hi), .conv_result_i(conv_result_i),
		.conv_valid_i(conv_valid_i), .reg_select_pointer_o(reg_select_pointer_o),
		.temperature_result_o(temperature_result_o), .busy_o(busy_o));
	tsi_asserts u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_o(bus_if.scl_o),
		.scl_oe_b(bus_if.scl_oe_b), .hsda_o(bus_if.hsda_o), .hsda_oe_b(bus_if.hsda_oe_b),
		.tsda_o(bus_if.tsda_o), .tsda_oe_b(bus_if.tsda_oe_b), .scl(bus_if.scl), .sda(bus_if.sda));

	always #25 mclk_i = ~mclk_i;

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// a hung transaction must still reach the verdict
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			finish_test;
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// order one transaction, poll until done, then check the nack flag
	task automatic run(input logic [15:0] ctl, input logic nk);
		int n;
		n = 0;
		wr(4'h2, ctl);
		rd(4'h3, v);
		while (v[0] !== 1'b0 && n < 4000)
		begin
			rd(4'h3, v);
			n++;
		end
		chk("done", 16'h0000, {15'h0000, v[0]});
		chk("nack", {15'h0000, nk}, {15'h0000, v[1]});
	endtask

	task automatic read_word(input logic [15:0] exp);
		run(16'h0002, 1'b0);
		rd(4'h4, v);
		chk("word", exp, v);
	endtask

	task automatic conv(input logic [11:0] r);
		@(posedge mclk_i);
		conv_result_i <= r;
		conv_valid_i <= 1'b1;
		@(posedge mclk_i);
		conv_valid_i <= 1'b0;
	endtask

	initial
	begin
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		#1 chk("pointer", 16'h0000, {8'h00, reg_select_pointer_o});
		chk("temp reg", 16'h0000, temperature_result_o);
		chk("busy", 16'h0000, {15'h0000, busy_o});
		rd(4'hF, v);
		chk("unmapped", 16'h0000, v);
		read_word(16'h0000);
		$display("test reset done");
		// rows cycle through every strap code; the strap moves between transactions
		for (int i = 0; i < 6; i++)
		begin
			@(posedge mclk_i);
			strap <= rows[i][13:12];
			wr(4'h0, {9'h000, 7'h48 | {5'h00, rows[i][13:12]}});
			conv(rows[i][11:0]);
			repeat (2) @(posedge mclk_i);
			#1 chk("temp reg", {rows[i][11:0], 4'h0}, temperature_result_o);
			read_word({rows[i][11:0], 4'h0});
		end
		$display("test table done");
		wr(4'h1, 16'h00A5);
		run(16'h0001, 1'b0);
		chk("pointer", 16'h0005, {8'h00, reg_select_pointer_o});
		read_word(16'h0000);
		read_word(16'h0000);
		wr(4'h1, 16'h0000);
		run(16'h0001, 1'b0);
		read_word(16'h0010);
		$display("test pointer done");
		wr(4'h0, 16'h004B);
		run(16'h0002, 1'b1);
		// the target sees the stop only after its line filters
		repeat (8) @(posedge mclk_i);
		#1 chk("busy", 16'h0000, {15'h0000, busy_o});
		wr(4'h0, 16'h0049);
		$display("test address mismatch done");
		conv(12'h123);
		// new result lands mid-read: the word must still come from one conversion
		fork
			run(16'h0002, 1'b0);
			begin
				repeat (600) @(posedge mclk_i);
				conv(12'h456);
			end
		join
		rd(4'h4, v);
		chk("word", 16'h1230, v);
		read_word(16'h4560);
		$display("test atomic read done");
		// a second reset mid-run must clear pointer and result again
		wr(4'h1, 16'h0003);
		run(16'h0001, 1'b0);
		chk("pointer", 16'h0003, {8'h00, reg_select_pointer_o});
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		#1 chk("pointer", 16'h0000, {8'h00, reg_select_pointer_o});
		chk("temp reg", 16'h0000, temperature_result_o);
		chk("busy", 16'h0000, {15'h0000, busy_o});
		$display("test second reset done");
		finish_test;
	end
endmodule // tb
